// ==== include/cksel_pkg.sv ====
// package for the clock select, reset flag and pll configuration block
package cksel_pkg;
   // register offsets
   localparam logic [7:0] FLAG_OFS = 8'hF2;
   localparam logic [7:0] PLL_OFS  = 8'hF6;
   // clock flag field positions
   localparam int EXT_STOP_BIT  = 7;
   localparam int WDG_BIT       = 6;
   localparam int SOFT_BIT      = 5;
   localparam int XSTOP_BIT     = 4;
   localparam int DIV16_BIT     = 3;
   localparam int AUXACT_BIT    = 2;
   localparam int PLLSEL_BIT    = 0;
   // pll configuration field positions
   localparam int MULT_LSB      = 4;
   localparam int DIV_LSB       = 0;
   localparam logic [2:0] DIV_OFF_CODE = 3'h7;
   // reset values
   localparam logic [7:0] PLL_RESET = 8'h07;
   localparam logic [1:0] MULT_RESET = 2'h0;
   // halt restart pulse length
   localparam int RESTART_MS    = 12;
   localparam int CLK_MHZ       = 100;
   localparam int RESTART_CYC   = RESTART_MS * 1000 * CLK_MHZ;
   // reset cause
   typedef enum logic [1:0] {CAUSE_POWER, CAUSE_WDG, CAUSE_SOFT} cksel_cause_type;
   // selected system clock source
   typedef enum logic [1:0] {SRC_DIV16, SRC_OSC, SRC_PLL, SRC_AUX} cksel_src_type;
   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cksel_req_type;
endpackage

// ==== design/cksel_clock_select.sv ====
// clock source selection, reset cause flags and pll configuration registers
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cksel_clock_select #(
   parameter int RESTART_CYCLES = cksel_pkg::RESTART_CYC
) (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire cksel_pkg::cksel_cause_type resetCause,
   // register port
   input  wire cksel_pkg::cksel_req_type   regReq,
   output logic [7:0]                 rdata,
   // clock control inputs
   input  wire logic                  auxClockSelect,
   input  wire logic                  waitClockSelect,
   input  wire logic                  lowPowerWaitEnable,
   input  wire logic                  intSourceSelect,
   input  wire logic                  softResetEnable,
   input  wire logic                  watchdogEnabled,
   // events
   input  wire logic                  externalStopEvent,
   input  wire logic                  waitForInterrupt,
   input  wire logic                  haltInstruction,
   input  wire logic                  auxClockPresent,
   input  wire logic                  extResetLevel,
   // clock system outputs
   output cksel_pkg::cksel_src_type   clockSource,
   output logic [3:0]                 pllMultiplier,
   output logic [2:0]                 pllDivider,
   output logic                       pllEnable,
   output logic                       oscRunning,
   output logic                       oscClockHoldHigh,
   output logic                       oscOutputPinOe,
   output logic                       softResetReq,
   output logic                       clockChangeIrq
);
   logic       extStop_r;
   logic       wdgFlag_r;
   logic       softFlag_r;
   logic       xstopPend_r;
   logic       xstopSet_r;
   logic       div16_r;
   logic       pllSel_r;
   logic [1:0] mult_r;
   logic [2:0] div_r;
   logic       halted_r;
   logic [31:0] rstCnt_r;
   logic       lpWait_r;
   cksel_pkg::cksel_src_type src_r;
   cksel_pkg::cksel_src_type srcNxt;
   logic       auxWanted;
   logic       auxActive;
   logic       xtalStopped;
   logic       wrFlag;
   logic       wrPll;
   logic       irqPulse_r;

   // multiplier decode, used only for the pllMultiplier output
   function automatic logic [3:0] multOf(input logic [1:0] code);
      unique case (code)
         2'h2: multOf = 4'hE;
         2'h0: multOf = 4'hA;
         2'h3: multOf = 4'h8;
         2'h1: multOf = 4'h6;
      endcase
   endfunction

   assign wrFlag = regReq.wr && (regReq.addr == cksel_pkg::FLAG_OFS);
   assign wrPll  = regReq.wr && (regReq.addr == cksel_pkg::PLL_OFS);

   // aux selection is honoured only while the aux clock really runs
   assign auxWanted = (auxClockSelect || (lpWait_r && waitClockSelect))
                      && auxClockPresent;
   assign auxActive = (src_r == cksel_pkg::SRC_AUX);
   assign xtalStopped = xstopSet_r && auxActive;

   // low power wait state held from wait entry until software leaves it
   always_ff @(posedge mclk) begin
      if (rst) begin
         lpWait_r <= 1'b0;
      end else if (waitForInterrupt && lowPowerWaitEnable) begin
         lpWait_r <= 1'b1;
      end else if (regReq.wr) begin
         lpWait_r <= 1'b0;                                                 // any write resumes
      end
   end

   // reset cause flags, loaded at each reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         wdgFlag_r  <= (resetCause == cksel_pkg::CAUSE_WDG);
         softFlag_r <= (resetCause == cksel_pkg::CAUSE_SOFT);
      end
   end

   // external stop flag: hardware set wins over software clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         extStop_r <= 1'b0;
      end else if (externalStopEvent) begin
         extStop_r <= 1'b1;
      end else if (wrFlag && !regReq.wdata[cksel_pkg::EXT_STOP_BIT]) begin
         extStop_r <= 1'b0;
      end
   end

   // crystal stop enable: pending until aux clock active
   always_ff @(posedge mclk) begin
      if (rst) begin
         xstopPend_r <= 1'b0;
         xstopSet_r  <= 1'b0;
      end else if (wrFlag && !regReq.wdata[cksel_pkg::XSTOP_BIT]) begin
         xstopPend_r <= 1'b0;
         xstopSet_r  <= 1'b0;
      end else if (wrFlag) begin
         xstopPend_r <= 1'b1;
      end else if (xstopPend_r && auxActive) begin
         xstopSet_r  <= 1'b1;
      end
   end

   // divide-by-16 select, forced to zero during low power wait
   always_ff @(posedge mclk) begin
      if (rst) begin
         div16_r <= 1'b1;
      end else if (waitForInterrupt && lowPowerWaitEnable) begin
         div16_r <= 1'b0;
      end else if (wrFlag) begin
         div16_r <= regReq.wdata[cksel_pkg::DIV16_BIT];
      end
   end

   // pll select with hardware clears
   always_ff @(posedge mclk) begin
      if (rst) begin
         pllSel_r <= 1'b0;
      end else if ((wrPll && regReq.wdata[2:0] == cksel_pkg::DIV_OFF_CODE)
                   || xtalStopped || halted_r
                   || (xstopPend_r && auxActive)
                   || (waitForInterrupt && lowPowerWaitEnable)
                   || !div16_r
                   || (wrFlag && !regReq.wdata[cksel_pkg::DIV16_BIT])) begin
         pllSel_r <= 1'b0;
      end else if (wrFlag) begin
         pllSel_r <= regReq.wdata[cksel_pkg::PLLSEL_BIT];
      end
   end

   // pll configuration
   always_ff @(posedge mclk) begin
      if (rst) begin
         mult_r <= cksel_pkg::MULT_RESET;
         div_r  <= cksel_pkg::DIV_OFF_CODE;
      end else if (wrPll) begin
         mult_r <= regReq.wdata[cksel_pkg::MULT_LSB +: 2];
         div_r  <= regReq.wdata[cksel_pkg::DIV_LSB +: 3];
      end
   end

   // halt: oscillator stops unless the watchdog runs or soft reset is enabled; long reset pulse restarts
   always_ff @(posedge mclk) begin
      if (rst) begin
         halted_r <= 1'b0;
         rstCnt_r <= 32'h0;
      end else if (haltInstruction && !softResetEnable && !watchdogEnabled) begin
         halted_r <= 1'b1;
      end else if (halted_r) begin
         if (!extResetLevel) begin
            rstCnt_r <= 32'h0;
         end else if (rstCnt_r >= 32'(RESTART_CYCLES - 1)) begin
            halted_r <= 1'b0;
            rstCnt_r <= 32'h0;
         end else begin
            rstCnt_r <= rstCnt_r + 32'h1;
         end
      end
   end

   // source choice: aux first, then div16, then pll or oscillator
   always_comb begin
      if (auxWanted) begin
         srcNxt = cksel_pkg::SRC_AUX;
      end else if (!div16_r) begin
         srcNxt = cksel_pkg::SRC_DIV16;
      end else if (pllSel_r && div_r != cksel_pkg::DIV_OFF_CODE) begin
         srcNxt = cksel_pkg::SRC_PLL;
      end else begin
         srcNxt = cksel_pkg::SRC_OSC;
      end
   end

   // the switch is one registered update so status follows the clock mux
   always_ff @(posedge mclk) begin
      if (rst) begin
         src_r <= cksel_pkg::SRC_OSC;
      end else begin
         src_r <= srcNxt;
      end
   end

   // clock change event pulse, masked by interrupt source select
   always_ff @(posedge mclk) begin
      if (rst) begin
         irqPulse_r <= 1'b0;
      end else begin
         irqPulse_r <= intSourceSelect && (src_r != srcNxt)
                       && (srcNxt == cksel_pkg::SRC_AUX
                           || src_r == cksel_pkg::SRC_AUX
                           || srcNxt == cksel_pkg::SRC_DIV16
                           || src_r == cksel_pkg::SRC_DIV16);
      end
   end
   assign clockChangeIrq = irqPulse_r;

   // read data registered, one cycle after strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (regReq.rd && regReq.addr == cksel_pkg::FLAG_OFS) begin
         rdata <= {extStop_r, wdgFlag_r, softFlag_r, xstopSet_r,
                   div16_r, auxActive, 1'b0, pllSel_r};
      end else if (regReq.rd && regReq.addr == cksel_pkg::PLL_OFS) begin
         rdata <= {2'h0, mult_r, 1'b0, div_r};
      end else begin
         rdata <= 8'h00;
      end
   end

   assign clockSource      = src_r;
   assign pllMultiplier    = multOf(mult_r);
   assign pllDivider       = div_r;
   assign pllEnable        = div16_r && (div_r != cksel_pkg::DIV_OFF_CODE)
                             && !lpWait_r && !halted_r;
   assign oscRunning       = !halted_r && !xtalStopped;
   assign oscClockHoldHigh = halted_r;
   assign oscOutputPinOe   = oscRunning;
   assign softResetReq     = haltInstruction && softResetEnable;

   // software clear must not lose a simultaneous stop event
   ext_stop_a: assert property (@(posedge mclk) disable iff (rst)
      externalStopEvent |=> extStop_r) else $error("stop flag lost");
   aux_prio_a: assert property (@(posedge mclk) disable iff (rst)
      auxWanted |=> clockSource == cksel_pkg::SRC_AUX) else $error("aux not first");
   div16_src_a: assert property (@(posedge mclk) disable iff (rst)
      (!div16_r && !auxWanted) |-> !pllEnable ##1 clockSource == cksel_pkg::SRC_DIV16)
      else $error("div16 not chosen");
   pll_clear_a: assert property (@(posedge mclk) disable iff (rst)
      (wrPll && regReq.wdata[2:0] == cksel_pkg::DIV_OFF_CODE) |=> !pllSel_r)
      else $error("pll select kept");
   xstop_pend_a: assert property (@(posedge mclk) disable iff (rst)
      (wrFlag && regReq.wdata[cksel_pkg::XSTOP_BIT] && !auxActive && !xstopSet_r)
      |=> !xstopSet_r) else $error("stop bit early");
   irq_mask_a: assert property (@(posedge mclk) disable iff (rst)
      !$past(intSourceSelect) |-> !clockChangeIrq) else $error("irq unmasked");
   halt_osc_a: assert property (@(posedge mclk) disable iff (rst)
      (haltInstruction && watchdogEnabled && !halted_r) |=> !halted_r)
      else $error("halt with watchdog");
   osc_pin_a: assert property (@(posedge mclk) disable iff (rst)
      halted_r |-> !oscOutputPinOe && oscClockHoldHigh) else $error("pin driven");
   mult_map_a: assert property (@(posedge mclk) disable iff (rst)
      mult_r == 2'h2 |-> pllMultiplier == 4'hE) else $error("bad multiplier");
   rd_lat_a: assert property (@(posedge mclk) disable iff (rst)
      (regReq.rd && regReq.addr == cksel_pkg::PLL_OFS) |=> rdata[2:0] == div_r)
      else $error("bad read");

   // a written zero drops both the pending and the active stop request
   xstop_cancel_a: assert property (@(posedge mclk) disable iff (rst)
      (wrFlag && !regReq.wdata[cksel_pkg::XSTOP_BIT]) |=> !xstopSet_r)
      else $error("stop not cancelled");

   // software owns the divide select unless low power wait forces it
   div16_wr_a: assert property (@(posedge mclk) disable iff (rst)
      (wrFlag && !(waitForInterrupt && lowPowerWaitEnable))
      |=> div16_r == $past(regReq.wdata[cksel_pkg::DIV16_BIT])) else $error("div16 lost");

   // cause flags only move while reset is applied
   ro_flags_a: assert property (@(posedge mclk) disable iff (rst)
      $stable(wdgFlag_r) && $stable(softFlag_r))
      else $error("cause flag moved");

   // a missing aux clock can never become the system clock
   aux_refuse_a: assert property (@(posedge mclk) disable iff (rst)
      !auxClockPresent |=> clockSource != cksel_pkg::SRC_AUX)
      else $error("absent aux taken");

   // pll stays off for the whole low power wait
   lpw_pll_a: assert property (@(posedge mclk) disable iff (rst)
      lpWait_r |-> !pllEnable)
      else $error("pll on in wait");

   // entering the divided clock raises the event while unmasked
   irq_raise_a: assert property (@(posedge mclk) disable iff (rst)
      (intSourceSelect && src_r != srcNxt && srcNxt == cksel_pkg::SRC_DIV16)
      |=> clockChangeIrq) else $error("irq missing");

   // divider code 111 keeps the pll powered down
   pll_off_a: assert property (@(posedge mclk) disable iff (rst)
      div_r == cksel_pkg::DIV_OFF_CODE |-> !pllEnable)
      else $error("pll on at 111");

   // a zero write clears the stop flag when no new stop arrives
   ext_clear_a: assert property (@(posedge mclk) disable iff (rst)
      (wrFlag && !regReq.wdata[cksel_pkg::EXT_STOP_BIT] && !externalStopEvent)
      |=> !extStop_r) else $error("stop flag kept");

   // a halt that requests a reset must not also stop the oscillator
   soft_halt_a: assert property (@(posedge mclk) disable iff (rst)
      (haltInstruction && softResetEnable && !halted_r) |=> !halted_r)
      else $error("halt with reset");

   // read data stands only in the cycle after a read strobe
   rd_idle_a: assert property (@(posedge mclk) disable iff (rst)
      !regReq.rd |=> rdata == 8'h00)
      else $error("stale read data");

   // the divided clock never leaves the pll selected
   div16_pll_a: assert property (@(posedge mclk) disable iff (rst)
      !div16_r |=> !pllSel_r)
      else $error("pll kept at div16");

   // the pll select drops in the cycle the crystal stops
   xstop_pll_a: assert property (@(posedge mclk) disable iff (rst)
      (xstopPend_r && auxActive) |=> !pllSel_r)
      else $error("pll kept at stop");

   // without an external reset the halted oscillator stays off
   halt_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (halted_r && !extResetLevel) |=> halted_r)
      else $error("halt left early");

   // a running oscillator drives its pin
   osc_pin_on_a: assert property (@(posedge mclk) disable iff (rst)
      (!halted_r && !xtalStopped) |-> oscOutputPinOe)
      else $error("pin released");

   // wait entry forces the divided clock and drops the pll select
   lpw_force_a: assert property (@(posedge mclk) disable iff (rst)
      (waitForInterrupt && lowPowerWaitEnable) |=> !div16_r && !pllSel_r)
      else $error("wait not forced");

   // flag reads return the stored reset cause
   flag_rd_a: assert property (@(posedge mclk) disable iff (rst)
      (regReq.rd && regReq.addr == cksel_pkg::FLAG_OFS)
      |=> rdata[cksel_pkg::WDG_BIT] == wdgFlag_r && rdata[cksel_pkg::SOFT_BIT] == softFlag_r)
      else $error("bad flag read");

   // divider 111 with no other choice runs the plain oscillator clock
   src_osc_a: assert property (@(posedge mclk) disable iff (rst)
      (!auxWanted && div16_r && div_r == cksel_pkg::DIV_OFF_CODE)
      |=> clockSource == cksel_pkg::SRC_OSC) else $error("osc not chosen");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking testbench for the clock select, reset flag and pll configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [7:0] wdata;
      logic [3:0] mult;
   } cksel_row_type;
   localparam logic [7:0] FLG = cksel_pkg::FLAG_OFS;
   localparam logic [7:0] PLL = cksel_pkg::PLL_OFS;
   logic                       mclk;
   logic                       rst;
   cksel_pkg::cksel_cause_type resetCause;
   cksel_pkg::cksel_req_type   req;
   logic [7:0]                 rdata;
   logic                       auxSel, waitSel, lpWait, intSel, softEn, wdgEn;
   logic                       auxPresent, extReset;
   logic [2:0]                 evt;
   cksel_pkg::cksel_src_type   clockSource;
   logic [3:0]                 pllMultiplier;
   logic [2:0]                 pllDivider;
   logic                       pllEnable, oscRunning, oscClockHoldHigh, oscOutputPinOe;
   logic                       softResetReq, clockChangeIrq;
   int                         n_fail, n_checks, nIrq, irqBase;
   logic [7:0]                 rstVal [3] = '{8'h08, 8'h48, 8'h28};
   cksel_row_type              rows [4] = '{'{8'h21, 4'hE}, '{8'h05, 4'hA},
                                            '{8'h36, 4'h8}, '{8'h10, 4'h6}};

   // short restart count keeps the halt scenario brief
   cksel_clock_select #(.RESTART_CYCLES(8)) i_cksel_clock_select (
      .mclk(mclk), .rst(rst), .resetCause(resetCause), .regReq(req), .rdata(rdata),
      .auxClockSelect(auxSel), .waitClockSelect(waitSel), .lowPowerWaitEnable(lpWait),
      .intSourceSelect(intSel), .softResetEnable(softEn), .watchdogEnabled(wdgEn),
      .externalStopEvent(evt[0]), .waitForInterrupt(evt[1]), .haltInstruction(evt[2]),
      .auxClockPresent(auxPresent), .extResetLevel(extReset), .clockSource(clockSource),
      .pllMultiplier(pllMultiplier), .pllDivider(pllDivider), .pllEnable(pllEnable),
      .oscRunning(oscRunning), .oscClockHoldHigh(oscClockHoldHigh),
      .oscOutputPinOe(oscOutputPinOe), .softResetReq(softResetReq),
      .clockChangeIrq(clockChangeIrq));

   // 100 MHz clock
   always #5 mclk = ~mclk;

   // interrupt pulses are counted so a missing or doubled pulse shows up
   always @(posedge mclk) begin
      if (clockChangeIrq === 1'b1) nIrq <= nIrq + 1;
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk) req <= '0;
   endtask

   // read data stands only in the cycle after the strobe, so sample it right there
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk) req <= '0;
      #1 chk("read data", rdata, exp);
   endtask

   task automatic pulse(input int i);
      @(posedge mclk) evt[i] <= 1'b1;
      @(posedge mclk) evt[i] <= 1'b0;
   endtask

   // switching is one registered update, so wait up to 50 cycles for the new source
   task automatic srcIs(input cksel_pkg::cksel_src_type s);
      int k;
      k = 0;
      while (clockSource !== s && k < 50) begin
         @(posedge mclk);
         k++;
      end
      #1 chk("source", {6'h00, clockSource}, {6'h00, s});
   endtask

   task automatic doReset(input int c);
      @(posedge mclk) begin
         rst <= 1'b1;
         resetCause <= cksel_pkg::cksel_cause_type'(c[1:0]);
      end
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // hang guard, far beyond the under two hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      finish_test;
   end

   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      resetCause = cksel_pkg::CAUSE_POWER;
      req = '0;
      {auxSel, waitSel, lpWait, intSel, softEn, wdgEn, auxPresent, extReset} = '0;
      evt = '0;
      {n_fail, n_checks, nIrq} = '0;
      // reset value per cause, ending on power-on
      for (int c = 2; c >= 0; c--) begin
         doReset(c);
         rd(FLG, rstVal[c]);
      end
      rd(PLL, 8'h07);
      srcIs(cksel_pkg::SRC_OSC);
      chk("pll enable", {7'h00, pllEnable}, 8'h00);
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h00);
      rd(FLG, 8'h08);
      foreach (rows[i]) begin
         wr(PLL, rows[i].wdata);
         rd(PLL, rows[i].wdata);
         chk("multiplier", {4'h0, pllMultiplier}, {4'h0, rows[i].mult});
         chk("divider", {5'h00, pllDivider}, {5'h00, rows[i].wdata[2:0]});
      end
      // pll select, then cleared by divider code 111
      wr(FLG, 8'h09); // no lock model, select set at once
      rd(FLG, 8'h09);
      srcIs(cksel_pkg::SRC_PLL);
      wr(PLL, 8'h07);
      rd(FLG, 8'h08);
      srcIs(cksel_pkg::SRC_OSC);
      // divide-by-16 toggles with interrupt enabled, then masked
      @(posedge mclk) intSel <= 1'b1;
      wr(PLL, 8'h01);
      wr(FLG, 8'h09);
      irqBase = nIrq;
      wr(FLG, 8'h01);
      rd(FLG, 8'h00);
      srcIs(cksel_pkg::SRC_DIV16);
      chk("pll enable", {7'h00, pllEnable}, 8'h00);
      chk("irq count", 8'(nIrq - irqBase), 8'h01);
      @(posedge mclk) intSel <= 1'b0;
      irqBase = nIrq;
      wr(FLG, 8'h08);
      srcIs(cksel_pkg::SRC_OSC);
      repeat (3) @(posedge mclk);
      chk("masked irq", 8'(nIrq - irqBase), 8'h00);
      // crystal stop request pending, cancelled, then honoured once aux runs
      wr(FLG, 8'h09);
      @(posedge mclk) auxSel <= 1'b1;
      wr(FLG, 8'h19);
      rd(FLG, 8'h09);
      srcIs(cksel_pkg::SRC_PLL);
      wr(FLG, 8'h09);
      @(posedge mclk) auxPresent <= 1'b1;
      srcIs(cksel_pkg::SRC_AUX);
      rd(FLG, 8'h0D);
      chk("osc running", {7'h00, oscRunning}, 8'h01);
      wr(FLG, 8'h19);
      rd(FLG, 8'h1C);
      chk("osc running", {7'h00, oscRunning}, 8'h00);
      chk("osc pin oe", {7'h00, oscOutputPinOe}, 8'h00);
      @(posedge mclk) auxSel <= 1'b0;
      wr(FLG, 8'h08); // restart wait not modelled here
      srcIs(cksel_pkg::SRC_OSC);
      chk("osc running", {7'h00, oscRunning}, 8'h01);
      // external stop flag and read-only bits
      pulse(0);
      rd(FLG, 8'h88);
      wr(FLG, 8'h08);
      rd(FLG, 8'h08);
      wr(FLG, 8'hEC); // whole byte written, never read-modify-write
      rd(FLG, 8'h08);
      // low-power wait drops the pll and forces the divided clock
      wr(FLG, 8'h09);
      @(posedge mclk) lpWait <= 1'b1;
      pulse(1);
      srcIs(cksel_pkg::SRC_DIV16);
      rd(FLG, 8'h00);
      chk("pll enable", {7'h00, pllEnable}, 8'h00);
      @(posedge mclk) lpWait <= 1'b0;
      wr(FLG, 8'h08);
      // halt with and without watchdog, software reset request
      @(posedge mclk) wdgEn <= 1'b1;
      pulse(2);
      #1 chk("osc running", {7'h00, oscRunning}, 8'h01);
      @(posedge mclk) begin
         wdgEn <= 1'b0;
         softEn <= 1'b1;
         evt[2] <= 1'b1;
      end
      #1 chk("soft reset req", {7'h00, softResetReq}, 8'h01);
      @(posedge mclk) begin
         softEn <= 1'b0;
         evt[2] <= 1'b0;
      end
      pulse(2);
      repeat (2) @(posedge mclk);
      #1 chk("osc running", {7'h00, oscRunning}, 8'h00);
      chk("clock hold high", {7'h00, oscClockHoldHigh}, 8'h01);
      chk("osc pin oe", {7'h00, oscOutputPinOe}, 8'h00);
      @(posedge mclk) extReset <= 1'b1;
      repeat (4) @(posedge mclk);
      extReset <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk("osc running", {7'h00, oscRunning}, 8'h00);
      @(posedge mclk) extReset <= 1'b1;
      repeat (12) @(posedge mclk);
      extReset <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk("osc running", {7'h00, oscRunning}, 8'h01);
      chk("clock hold high", {7'h00, oscClockHoldHigh}, 8'h00);
      finish_test;
   end
endmodule
`default_nettype wire
